// >>> rtl/sys_pll_pkg.sv
// Constants and types for the system PLL configuration and status block
package sys_pll_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets, fixed across every variant of the family
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FREQ_M_LO = 8'h04;
    localparam logic [7:0] REG_FREQ_M_HI = 8'h08;
    localparam logic [7:0] REG_FREQ_N = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] REG_GPIO_CFG = 8'h1c;

    // Control field layout: doubler select and feedback divider
    localparam int CTRL_DBL_BIT = 0;
    localparam int CTRL_DIV_LSB = 1;
    localparam int CTRL_DIV_W = 10;
    localparam int CTRL_W = 16;

    // Frequency word widths
    localparam int FREQ_M_W = 48;
    localparam int FREQ_N_W = 16;

    // Feedback divider limits and reset values
    localparam logic [9:0] FB_DIV_MIN = 10'h06c;
    localparam logic [9:0] FB_DIV_MAX = 10'h22c;
    localparam logic [9:0] FB_DIV_RST = 10'h10e;
    localparam logic DBL_RST = 1'b0;
    localparam logic [47:0] FREQ_M_RST = 48'h0000_0000_0000;
    localparam logic [15:0] FREQ_N_RST = 16'h0001;

    // Status bit positions
    localparam int ST_LOCKED = 0;
    localparam int ST_LOL = 1;
    localparam int ST_BOOT_DONE = 2;
    localparam int ST_SRC_LSB = 4;
    localparam int ST_XTAL = 6;

    // Boot source codes
    localparam logic [1:0] SRC_DEFAULT = 2'h0;
    localparam logic [1:0] SRC_OTP = 2'h1;
    localparam logic [1:0] SRC_EEPROM = 2'h2;

    // Interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_LOL = 0;
    localparam int IRQ_LOCK = 1;
    localparam int IRQ_BOOT = 2;
    localparam int IRQ_REJECT = 3;

    // GPIO configuration bits
    localparam int GPIO_EN_BIT = 0;
    localparam int GPIO_INV_BIT = 1;

    // Lock window around the expected loop control level
    localparam logic [7:0] LOCK_MARGIN = 8'h10;
    localparam logic [7:0] DBL_MARGIN = 8'h08;

    // Timing
    localparam int CLK_MHZ = 10;
    localparam int LOCK_QUAL_NS = 10000;
    localparam int LOCK_QUAL_CYC = (LOCK_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam int EE_HALF_NS = 500;
    localparam int EE_HALF_CYC = (EE_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC = 3;

    // Serial EEPROM image: signature byte then control field
    localparam int EE_BITS = 24;
    localparam logic [7:0] EE_SIG = 8'ha5;

    typedef enum logic [3:0] {
        BOOT_SETTLE = 4'b0001,
        BOOT_SELECT = 4'b0010,
        BOOT_EEPROM = 4'b0100,
        BOOT_DONE = 4'b1000
    } boot_state_t;

endpackage : sys_pll_pkg

// >>> rtl/system_pll_config_status.sv
// System PLL configuration, boot load, lock detect and alarm logic
//
// Notes on behaviour
// - Frequencies are held as 48-bit numerator over 16-bit denominator.
// - A control bit selects crystal direct or through the doubler.
// - Feedback divider accepts 108 to 556; other values are refused.
// - At reset the control field loads from OTP or EEPROM if valid.
// - After boot the host may rewrite PLL configuration at any time.
// - Lock is judged from loop level against limits derived from config.
// - Loss-of-lock alarm is readable in status and routable to a GPIO.
// - Register offsets are fixed, matching all family variants.
// - PLL runs only while the crystal input is present.
`timescale 1ns/10ps
module system_pll_config_status (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    input wire logic xtal_present_i,
    input wire logic otp_enable_i,
    input wire logic otp_valid_i,
    input wire logic [15:0] otp_ctrl_i,
    input wire logic eeprom_enable_i,
    input wire logic eeprom_sdi_i,
    output logic eeprom_cs_n_o,
    output logic eeprom_sclk_o,
    input wire logic [7:0] loop_ctrl_level_i,
    output logic pll_enable_o,
    output logic pll_doubler_en_o,
    output logic [9:0] pll_fb_div_o,
    output logic gpio_o,
    output logic gpio_oe_o,
    output logic boot_done_o
);

    localparam int SYNC_W = 29;

    function automatic logic fb_div_ok(input logic [9:0] div);
        fb_div_ok = (div >= sys_pll_pkg::FB_DIV_MIN) &&
                    (div <= sys_pll_pkg::FB_DIV_MAX);
    endfunction : fb_div_ok

    function automatic logic [9:0] ctrl_div(input logic [15:0] word);
        ctrl_div = word[sys_pll_pkg::CTRL_DIV_LSB +: sys_pll_pkg::CTRL_DIV_W];
    endfunction : ctrl_div

    // Synchronisers for every pin input except the register port and reset
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic xtal_s;
    logic otp_en_s;
    logic otp_valid_s;
    logic [15:0] otp_ctrl_s;
    logic ee_en_s;
    logic sdi_s;
    logic [7:0] level_s;

    // Loop level is a slow analog reading; bit skew here is tolerated
    // because lock needs many consecutive in-window samples anyway.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {xtal_present_i, otp_enable_i, otp_valid_i, otp_ctrl_i,
                       eeprom_enable_i, eeprom_sdi_i, loop_ctrl_level_i};
            sync_b <= sync_a;
        end
    end

    assign xtal_s = sync_b[28];
    assign otp_en_s = sync_b[27];
    assign otp_valid_s = sync_b[26];
    assign otp_ctrl_s = sync_b[25:10];
    assign ee_en_s = sync_b[9];
    assign sdi_s = sync_b[8];
    assign level_s = sync_b[7:0];

    // Boot loader
    sys_pll_pkg::boot_state_t state;
    logic [3:0] wait_cnt;
    logic [4:0] bit_cnt;
    logic [22:0] shift;
    logic boot_load;
    logic [15:0] boot_word;
    logic [1:0] boot_src;
    logic boot_pulse;
    logic [15:0] ee_word;

    assign ee_word = {shift[14:0], sdi_s};

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= sys_pll_pkg::BOOT_SETTLE;
            wait_cnt <= '0;
            bit_cnt <= '0;
            shift <= '0;
            boot_load <= 1'b0;
            boot_word <= '0;
            boot_src <= sys_pll_pkg::SRC_DEFAULT;
            boot_pulse <= 1'b0;
            eeprom_cs_n_o <= 1'b1;
            eeprom_sclk_o <= 1'b0;
        end else begin
            boot_load <= 1'b0;
            boot_pulse <= 1'b0;
            unique case (state)
                sys_pll_pkg::BOOT_SETTLE: begin
                    // Straps pass the synchronisers before they are trusted
                    if (wait_cnt == 4'(sys_pll_pkg::SETTLE_CYC - 1)) begin
                        wait_cnt <= '0;
                        state <= sys_pll_pkg::BOOT_SELECT;
                    end else begin
                        wait_cnt <= wait_cnt + 4'h1;
                    end
                end
                sys_pll_pkg::BOOT_SELECT: begin
                    if (otp_en_s && otp_valid_s &&
                        fb_div_ok(ctrl_div(otp_ctrl_s))) begin
                        boot_load <= 1'b1;
                        boot_word <= otp_ctrl_s;
                        boot_src <= sys_pll_pkg::SRC_OTP;
                        boot_pulse <= 1'b1;
                        state <= sys_pll_pkg::BOOT_DONE;
                    end else if (ee_en_s) begin
                        eeprom_cs_n_o <= 1'b0;
                        state <= sys_pll_pkg::BOOT_EEPROM;
                    end else begin
                        boot_pulse <= 1'b1;
                        state <= sys_pll_pkg::BOOT_DONE;
                    end
                end
                sys_pll_pkg::BOOT_EEPROM: begin
                    if (wait_cnt == 4'(sys_pll_pkg::EE_HALF_CYC - 1)) begin
                        wait_cnt <= '0;
                        eeprom_sclk_o <= ~eeprom_sclk_o;
                        // Sample at the end of the high phase, well after
                        // the synchroniser delay of the data pin
                        if (eeprom_sclk_o) begin
                            shift <= {shift[21:0], sdi_s};
                            if (bit_cnt == 5'(sys_pll_pkg::EE_BITS - 1)) begin
                                eeprom_cs_n_o <= 1'b1;
                                boot_pulse <= 1'b1;
                                state <= sys_pll_pkg::BOOT_DONE;
                                if (shift[22:15] == sys_pll_pkg::EE_SIG &&
                                    fb_div_ok(ctrl_div(ee_word))) begin
                                    boot_load <= 1'b1;
                                    boot_word <= ee_word;
                                    boot_src <= sys_pll_pkg::SRC_EEPROM;
                                end
                            end else begin
                                bit_cnt <= bit_cnt + 5'h01;
                            end
                        end
                    end else begin
                        wait_cnt <= wait_cnt + 4'h1;
                    end
                end
                sys_pll_pkg::BOOT_DONE: begin
                    eeprom_sclk_o <= 1'b0;
                end
                default: begin
                    state <= sys_pll_pkg::BOOT_SETTLE;
                end
            endcase
        end
    end

    // Done only once the loaded field is in place, so no host write is lost
    assign boot_done_o = (state == sys_pll_pkg::BOOT_DONE) && !boot_load;

    // Register access decode
    logic wr_ctrl;
    logic host_ok;
    logic [9:0] new_div;
    logic reject;

    // Control and frequency writes before the boot load ends would race the loader, so drop them
    assign host_ok = boot_done_o && !boot_load;
    assign wr_ctrl = reg_wr_i && host_ok &&
                     (reg_addr_i == sys_pll_pkg::REG_CTRL);
    assign new_div = reg_wdata_i[sys_pll_pkg::CTRL_DIV_LSB +:
                                 sys_pll_pkg::CTRL_DIV_W];
    assign reject = wr_ctrl && !fb_div_ok(new_div);

    // PLL control field
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pll_doubler_en_o <= sys_pll_pkg::DBL_RST;
            pll_fb_div_o <= sys_pll_pkg::FB_DIV_RST;
        end else if (boot_load) begin
            pll_doubler_en_o <= boot_word[sys_pll_pkg::CTRL_DBL_BIT];
            pll_fb_div_o <= ctrl_div(boot_word);
        end else if (wr_ctrl && !reject) begin
            pll_doubler_en_o <= reg_wdata_i[sys_pll_pkg::CTRL_DBL_BIT];
            pll_fb_div_o <= new_div;
        end
    end

    // Frequency word, numerator over denominator
    logic [47:0] freq_m;
    logic [15:0] freq_n;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            freq_m <= sys_pll_pkg::FREQ_M_RST;
            freq_n <= sys_pll_pkg::FREQ_N_RST;
        end else if (reg_wr_i && host_ok) begin
            if (reg_addr_i == sys_pll_pkg::REG_FREQ_M_LO) begin
                freq_m[31:0] <= reg_wdata_i;
            end
            if (reg_addr_i == sys_pll_pkg::REG_FREQ_M_HI) begin
                freq_m[47:32] <= reg_wdata_i[15:0];
            end
            // A zero denominator has no meaning and is kept out
            if (reg_addr_i == sys_pll_pkg::REG_FREQ_N &&
                reg_wdata_i[15:0] != 16'h0000) begin
                freq_n <= reg_wdata_i[15:0];
            end
        end
    end

    // Lock detection
    logic [8:0] centre;
    logic [8:0] margin;
    logic [8:0] lim_lo;
    logic [8:0] lim_hi;
    logic in_window;
    logic [7:0] qual_cnt;
    logic locked;
    logic locked_q;
    logic relock;

    assign pll_enable_o = xtal_s && boot_done_o;
    assign centre = {1'b0, pll_fb_div_o[9:2]};
    assign margin = {1'b0, sys_pll_pkg::LOCK_MARGIN} +
                    (pll_doubler_en_o ? {1'b0, sys_pll_pkg::DBL_MARGIN}
                                      : 9'h000);
    assign lim_lo = (centre > margin) ? centre - margin : 9'h000;
    assign lim_hi = centre + margin;
    assign in_window = ({1'b0, level_s} >= lim_lo) &&
                       ({1'b0, level_s} <= lim_hi);
    assign relock = boot_load || (wr_ctrl && !reject);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            qual_cnt <= '0;
            locked <= 1'b0;
        end else if (!pll_enable_o || !in_window || relock) begin
            qual_cnt <= '0;
            locked <= 1'b0;
        end else if (qual_cnt == 8'(sys_pll_pkg::LOCK_QUAL_CYC - 1)) begin
            locked <= 1'b1;
        end else begin
            qual_cnt <= qual_cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= locked;
        end
    end

    // Interrupts
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign irq_set[sys_pll_pkg::IRQ_LOL] = locked_q && !locked;
    assign irq_set[sys_pll_pkg::IRQ_LOCK] = !locked_q && locked;
    assign irq_set[sys_pll_pkg::IRQ_BOOT] = boot_pulse;
    assign irq_set[sys_pll_pkg::IRQ_REJECT] = reject;
    assign irq_clr = (reg_wr_i && reg_addr_i == sys_pll_pkg::REG_IRQ_STATUS)
                     ? reg_wdata_i[3:0] : 4'h0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_mask <= '0;
        end else if (reg_wr_i && reg_addr_i == sys_pll_pkg::REG_IRQ_MASK) begin
            irq_mask <= reg_wdata_i[3:0];
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // GPIO alarm routing
    logic [1:0] gpio_cfg;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gpio_cfg <= '0;
        end else if (reg_wr_i && reg_addr_i == sys_pll_pkg::REG_GPIO_CFG) begin
            gpio_cfg <= reg_wdata_i[1:0];
        end
    end

    // Follows the live lock state, so no acknowledge is needed
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gpio_o <= 1'b0;
        end else begin
            gpio_o <= !locked ^ gpio_cfg[sys_pll_pkg::GPIO_INV_BIT];
        end
    end

    assign gpio_oe_o = gpio_cfg[sys_pll_pkg::GPIO_EN_BIT];

    // Read data, valid only in the cycle after the strobe
    logic [31:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[sys_pll_pkg::ST_LOCKED] = locked;
        status_word[sys_pll_pkg::ST_LOL] = !locked;
        status_word[sys_pll_pkg::ST_BOOT_DONE] = boot_done_o;
        status_word[sys_pll_pkg::ST_SRC_LSB +: 2] = boot_src;
        status_word[sys_pll_pkg::ST_XTAL] = xtal_s;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                sys_pll_pkg::REG_CTRL:
                    reg_rdata_o <= {21'h0, pll_fb_div_o,
                                    pll_doubler_en_o};
                sys_pll_pkg::REG_FREQ_M_LO:
                    reg_rdata_o <= freq_m[31:0];
                sys_pll_pkg::REG_FREQ_M_HI:
                    reg_rdata_o <= {16'h0000, freq_m[47:32]};
                sys_pll_pkg::REG_FREQ_N:
                    reg_rdata_o <= {16'h0000, freq_n};
                sys_pll_pkg::REG_STATUS:
                    reg_rdata_o <= status_word;
                sys_pll_pkg::REG_IRQ_STATUS:
                    reg_rdata_o <= {28'h0000000, irq_status};
                sys_pll_pkg::REG_IRQ_MASK:
                    reg_rdata_o <= {28'h0000000, irq_mask};
                sys_pll_pkg::REG_GPIO_CFG:
                    reg_rdata_o <= {30'h0, gpio_cfg};
                default:
                    reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule : system_pll_config_status

// >>> verification/sys_pll_eeprom_model.sv
// Serial EEPROM holding a boot image, shifted out MSB first
`timescale 1ns/10ps
module sys_pll_eeprom_model #(
    parameter logic [23:0] IMAGE = 24'ha50191
) (
    input wire logic cs_n_i,
    input wire logic sclk_i,
    output logic sdi_o
);
    int idx = 23;
    // Next bit after each falling edge; host samples late in high phase.
    // Deselect rewinds to the first bit; an unknown select counts as idle.
    always @(posedge cs_n_i or negedge sclk_i) begin
        if (cs_n_i !== 1'b0) begin
            idx = 23;
        end else if (idx > 0) begin
            idx--;
        end
    end
    // Deselected line floats: show the inverse so a stale sample shows
    assign sdi_o = cs_n_i ? ~IMAGE[idx] : IMAGE[idx];
endmodule : sys_pll_eeprom_model

// >>> verification/system_pll_config_status_monitor.sv
// Port-level assertions for the system PLL configuration block
`timescale 1ns/10ps
module system_pll_config_status_monitor (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic xtal_present_i,
    input wire logic eeprom_cs_n_o,
    input wire logic eeprom_sclk_o,
    input wire logic pll_enable_o,
    input wire logic pll_doubler_en_o,
    input wire logic [9:0] pll_fb_div_o,
    input wire logic gpio_oe_o,
    input wire logic boot_done_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic ctrl_wr;
    logic div_ok;
    assign ctrl_wr = reg_wr_i && reg_addr_i == sys_pll_pkg::REG_CTRL
        && boot_done_o;
    assign div_ok = reg_wdata_i[10:1] >= sys_pll_pkg::FB_DIV_MIN
        && reg_wdata_i[10:1] <= sys_pll_pkg::FB_DIV_MAX;

    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside read slot");
    a_div_range: assert property (
        pll_fb_div_o >= sys_pll_pkg::FB_DIV_MIN
        && pll_fb_div_o <= sys_pll_pkg::FB_DIV_MAX)
        else $error("feedback divider out of range");
    a_enable_boot: assert property (pll_enable_o |-> boot_done_o)
        else $error("PLL enabled before boot finished");
    a_xtal_gone: assert property (
        !xtal_present_i [*3] |-> !pll_enable_o)
        else $error("PLL enabled without crystal");
    a_sclk_select: assert property (
        eeprom_sclk_o |-> !eeprom_cs_n_o)
        else $error("serial clock while deselected");
    a_sclk_half: assert property (
        $rose(eeprom_sclk_o) |=> eeprom_sclk_o [*4] ##1 !eeprom_sclk_o)
        else $error("serial clock high phase wrong");
    a_ctrl_apply: assert property (
        ctrl_wr && div_ok |=> pll_fb_div_o == $past(reg_wdata_i[10:1])
        && pll_doubler_en_o == $past(reg_wdata_i[0]))
        else $error("control write not applied");
    a_ctrl_refuse: assert property (
        ctrl_wr && !div_ok |=> $stable(pll_fb_div_o)
        && $stable(pll_doubler_en_o))
        else $error("bad divider accepted");
    a_gpio_route: assert property (
        reg_wr_i && reg_addr_i == sys_pll_pkg::REG_GPIO_CFG
        |=> gpio_oe_o == $past(reg_wdata_i[0]))
        else $error("pin drive enable not applied");

    c_refused: cover property (ctrl_wr && !div_ok);
    c_ee_read: cover property ($fell(eeprom_cs_n_o));
    c_xtal_loss: cover property ($fell(pll_enable_o));
endmodule : system_pll_config_status_monitor

bind system_pll_config_status system_pll_config_status_monitor mon (
    .ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .xtal_present_i, .eeprom_cs_n_o, .eeprom_sclk_o,
    .pll_enable_o, .pll_doubler_en_o, .pll_fb_div_o, .gpio_oe_o,
    .boot_done_o
);

// >>> verification/system_pll_config_status_test.sv
// Self-checking bench for the system PLL configuration block
`timescale 1ns/10ps
module system_pll_config_status_test;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic irq_o;
    logic xtal_present_i = 1'b1;
    logic otp_enable_i = 1'b0;
    logic otp_valid_i = 1'b0;
    logic [15:0] otp_ctrl_i = 16'h00d9;
    logic eeprom_enable_i = 1'b1;
    logic eeprom_sdi_i;
    logic eeprom_cs_n_o;
    logic eeprom_sclk_o;
    logic [7:0] loop_ctrl_level_i = 8'h0;
    logic pll_enable_o;
    logic pll_doubler_en_o;
    logic [9:0] pll_fb_div_o;
    logic gpio_o;
    logic gpio_oe_o;
    logic boot_done_o;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] d;

    system_pll_config_status dut (.ref_clk_i, .reset_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
        .xtal_present_i, .otp_enable_i, .otp_valid_i, .otp_ctrl_i,
        .eeprom_enable_i, .eeprom_sdi_i, .eeprom_cs_n_o, .eeprom_sclk_o,
        .loop_ctrl_level_i, .pll_enable_o, .pll_doubler_en_o,
        .pll_fb_div_o, .gpio_o, .gpio_oe_o, .boot_done_o);
    sys_pll_eeprom_model eeprom (.cs_n_i(eeprom_cs_n_o),
        .sclk_i(eeprom_sclk_o), .sdi_o(eeprom_sdi_i));

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_sim;
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask : reg_read

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wait_cycles

    // Boot straps must be settled well before release
    task automatic do_reset(input logic [31:0] src);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        check("fb_div at reset", pll_fb_div_o, 32'h10e);
        check("boot_done at reset", boot_done_o, 32'h0);
        check("pll_enable at reset", pll_enable_o, 32'h0);
        reset_i <= 1'b0;
        for (int i = 0; i < 600 && boot_done_o !== 1'b1; i++) begin
            @(posedge ref_clk_i);
        end
        #1;
        check("boot_done", boot_done_o, 32'h1);
        reg_read(sys_pll_pkg::REG_STATUS, d);
        check("boot status", d & 32'h74, src | 32'h44);
        reg_read(sys_pll_pkg::REG_IRQ_STATUS, d);
        check("boot flag", d & 32'h4, 32'h4);
    endtask : do_reset

    task automatic test_ctrl_range;
        logic [9:0] divs [4] = '{10'h06b, 10'h06c, 10'h22c, 10'h22d};
        logic [9:0] exps [4] = '{10'h0c8, 10'h06c, 10'h22c, 10'h22c};
        for (int i = 0; i < 4; i++) begin
            reg_write(sys_pll_pkg::REG_CTRL, {21'h0, divs[i], 1'b0});
            check("fb_div", pll_fb_div_o, exps[i]);
        end
        check("doubler off", pll_doubler_en_o, 32'h0);
        reg_read(sys_pll_pkg::REG_IRQ_STATUS, d);
        check("reject flag", d & 32'h8, 32'h8);
        reg_write(sys_pll_pkg::REG_IRQ_STATUS, 32'h8);
        reg_read(sys_pll_pkg::REG_IRQ_STATUS, d);
        check("reject cleared", d & 32'h8, 32'h0);
    endtask : test_ctrl_range

    task automatic test_freq;
        reg_write(sys_pll_pkg::REG_FREQ_M_LO, 32'h89ab_cdef);
        reg_write(sys_pll_pkg::REG_FREQ_M_HI, 32'h0000_0123);
        reg_write(sys_pll_pkg::REG_FREQ_N, 32'h0000_009e);
        reg_write(sys_pll_pkg::REG_FREQ_N, 32'h0);
        reg_read(sys_pll_pkg::REG_FREQ_M_LO, d);
        check("freq m lo", d, 32'h89ab_cdef);
        reg_read(sys_pll_pkg::REG_FREQ_M_HI, d);
        check("freq m hi", d, 32'h0000_0123);
        reg_read(sys_pll_pkg::REG_FREQ_N, d);
        check("freq n", d, 32'h0000_009e);
        reg_read(8'h20, d);
        check("unmapped", d, 32'h0);
    endtask : test_freq

    task automatic test_lock_alarm;
        @(posedge ref_clk_i);
        loop_ctrl_level_i <= 8'h32;
        reg_write(sys_pll_pkg::REG_CTRL, 32'h191);
        check("doubler on", pll_doubler_en_o, 32'h1);
        reg_write(sys_pll_pkg::REG_GPIO_CFG, 32'h1);
        wait_cycles(130);
        reg_write(sys_pll_pkg::REG_IRQ_STATUS, 32'hf);
        reg_write(sys_pll_pkg::REG_IRQ_MASK, 32'h1);
        reg_read(sys_pll_pkg::REG_STATUS, d);
        check("locked", d & 32'h3, 32'h1);
        check("irq quiet", irq_o, 32'h0);
        check("gpio locked", {gpio_oe_o, gpio_o}, 32'h2);
        @(posedge ref_clk_i);
        loop_ctrl_level_i <= 8'h80;
        wait_cycles(6);
        reg_read(sys_pll_pkg::REG_STATUS, d);
        check("lock lost", d & 32'h3, 32'h2);
        check("gpio alarm", gpio_o, 32'h1);
        check("irq alarm", irq_o, 32'h1);
        reg_write(sys_pll_pkg::REG_GPIO_CFG, 32'h3);
        wait_cycles(2);
        check("gpio inverted", gpio_o, 32'h0);
        @(posedge ref_clk_i);
        loop_ctrl_level_i <= 8'h32;
        wait_cycles(130);
        reg_read(sys_pll_pkg::REG_STATUS, d);
        check("lol live", d & 32'h3, 32'h1);
        check("irq sticky", irq_o, 32'h1);
        reg_read(sys_pll_pkg::REG_IRQ_STATUS, d);
        check("lock flags", d & 32'h3, 32'h3);
        reg_write(sys_pll_pkg::REG_IRQ_STATUS, 32'h1);
        check("irq cleared", irq_o, 32'h0);
    endtask : test_lock_alarm

    task automatic test_xtal;
        @(posedge ref_clk_i);
        xtal_present_i <= 1'b0;
        wait_cycles(4);
        check("pll off", pll_enable_o, 32'h0);
        reg_read(sys_pll_pkg::REG_STATUS, d);
        check("xtal flag", d & 32'h40, 32'h0);
        @(posedge ref_clk_i);
        xtal_present_i <= 1'b1;
        wait_cycles(4);
        check("pll on", pll_enable_o, 32'h1);
    endtask : test_xtal

    initial begin
        do_reset(32'h20);
        check("ee divider", pll_fb_div_o, 32'h0c8);
        check("ee doubler", pll_doubler_en_o, 32'h1);
        test_ctrl_range();
        test_freq();
        test_lock_alarm();
        test_xtal();
        // Both sources valid: the one-time memory takes precedence
        @(posedge ref_clk_i);
        otp_enable_i <= 1'b1;
        otp_valid_i <= 1'b1;
        do_reset(32'h10);
        check("otp divider", pll_fb_div_o, 32'h06c);
        check("otp doubler", pll_doubler_en_o, 32'h1);
        // No source enabled: reset defaults must stay in place
        @(posedge ref_clk_i);
        otp_enable_i <= 1'b0;
        eeprom_enable_i <= 1'b0;
        do_reset(32'h0);
        check("default divider", pll_fb_div_o, 32'h10e);
        check("default doubler", pll_doubler_en_o, 32'h0);
        end_sim();
    end
endmodule : system_pll_config_status_test
